/* File: src/dp_line_if.sv */
`timescale 1ns/10ps
// Purpose: Carries sampled bus events and pin levels to the serial engine
// Assumes: All signals are on clk_i
// Notes: Events are one-cycle pulses
interface dp_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic start;
   logic stop;
   logic [1:0] strap;
   logic write_lock_n;
   modport src (output scl_rise, scl_fall, sda, start, stop, strap, write_lock_n);
   modport dst (input scl_rise, scl_fall, sda, start, stop, strap, write_lock_n);
endinterface

/* File: src/dp_line_sync.sv */
`timescale 1ns/10ps
// Purpose: Synchronises bus pins and straps, finds clock edges and start/stop
// Assumes: Bus clock far slower than clk_i
// Notes: First stage of each synchroniser feeds only the second
module dp_line_sync
   import dp_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic addr_strap_high_i,
   input wire logic addr_strap_low_i,
   input wire logic write_lock_n_i,
   dp_line_if.src line
);
   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;

   // Pins sampled twice before any use
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_ff <= 5'h1b;
         sync_ff <= 5'h1b;
      end else begin
         meta_ff <= {write_lock_n_i, addr_strap_high_i, addr_strap_low_i, sda_i, scl_i};
         sync_ff <= meta_ff;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= sync_ff[0];
         sda_d_ff <= sync_ff[1];
      end
   end

   assign line.scl_rise = sync_ff[0] & ~scl_d_ff;
   assign line.scl_fall = ~sync_ff[0] & scl_d_ff;
   assign line.sda = sync_ff[1];
   assign line.start = sync_ff[0] & scl_d_ff & sda_d_ff & ~sync_ff[1];
   assign line.stop = sync_ff[0] & scl_d_ff & ~sda_d_ff & sync_ff[1];
   assign line.strap = sync_ff[3:2];
   assign line.write_lock_n = sync_ff[4];
endmodule // dp_line_sync

/* File: src/dp_pkg.sv */
// Purpose: Shared constants for the 1024-tap digital potentiometer slave
// Assumes: 50 MHz system clock, bus clock sampled as a plain input
// Notes: Opcode values and two-byte data layout are local choices
package dp_pkg;
   localparam int WIPER_W = 10;
   localparam int TAP_COUNT = 1024;
   localparam int PRESET_NUM = 4;
   localparam logic [3:0] DEVICE_TYPE_CODE = 4'h0; // Arbitrary neutral value
   localparam logic [WIPER_W-1:0] PRESET_RST = 10'h000;
   localparam logic [WIPER_W-1:0] WIPER_RST = 10'h000;
   localparam int NV_WRITE_TIME_US = 5000;
   localparam int CLK_FREQ_MHZ = 50;
   localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_MHZ;
   // Address byte fields
   localparam int ADR_TYPE_POS = 4;
   localparam int ADR_ZERO_POS = 3;
   localparam int ADR_STRAP_POS = 1;
   localparam int ADR_RW_POS = 0;
   // Command byte fields
   localparam int CMD_OP_POS = 5;
   localparam int CMD_SEL_POS = 2;
   localparam logic [2:0] OP_RD_WIPER = 3'h4;
   localparam logic [2:0] OP_WR_WIPER = 3'h5;
   localparam logic [2:0] OP_RD_PRESET = 3'h6;
   localparam logic [2:0] OP_WR_PRESET = 3'h7;
   localparam logic [2:0] OP_PRESET_TO_WIPER = 3'h2;
   localparam logic [2:0] OP_WIPER_TO_PRESET = 3'h3;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] DATA_BYTES = 2'h2;

   typedef enum logic [5:0] {
      DP_IDLE = 6'h01,
      DP_ADDR = 6'h02,
      DP_CMD = 6'h04,
      DP_WDATA = 6'h08,
      DP_RDATA = 6'h10,
      DP_IGNORE = 6'h20
   } dp_state_t;
endpackage

/* File: src/dp_pot.sv */
`timescale 1ns/10ps
// Purpose: Digital control of a 1024-tap potentiometer behind a 2-wire slave port
// Assumes: Bus clock well below clk_i / 4; presets kept in flip-flops
// Notes: Data moves as two bytes, low byte first, high byte in bits 1:0
module dp_pot
   import dp_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_strap_high_i,
   input wire logic addr_strap_low_i,
   input wire logic write_lock_n_i,
   output logic [WIPER_W-1:0] wiper_position_o,
   output logic [TAP_COUNT-1:0] tap_sel_o,
   output logic nv_busy_o
);
   dp_line_if line ();

   dp_line_sync u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .addr_strap_high_i(addr_strap_high_i),
      .addr_strap_low_i(addr_strap_low_i),
      .write_lock_n_i(write_lock_n_i),
      .line(line.src)
   );

   function automatic logic [TAP_COUNT-1:0] tap_decode(input logic [WIPER_W-1:0] pos);
      logic [TAP_COUNT-1:0] v;
      v = '0;
      v[pos] = 1'b1;
      return v;
   endfunction

   dp_state_t state_ff;
   logic [3:0] bit_cnt_ff;
   logic ack_phase_ff;
   logic [7:0] rx_sh_ff;
   logic [7:0] tx_sh_ff;
   logic drive_low_ff;
   logic rw_ff;
   logic [2:0] op_ff;
   logic [1:0] sel_ff;
   logic [1:0] byte_idx_ff;
   logic [7:0] data_lo_ff;
   logic [WIPER_W-1:0] rd_val_ff;
   logic wip_ld_ff;
   logic [WIPER_W-1:0] wip_val_ff;
   logic nv_pend_ff;
   logic [1:0] nv_sel_ff;
   logic [WIPER_W-1:0] nv_val_ff;
   logic recall_ff;
   logic [31:0] busy_cnt_ff;
   logic busy_ff;
   logic [WIPER_W-1:0] wiper_position_reg;
   logic [WIPER_W-1:0] preset_ff [PRESET_NUM];
   logic [TAP_COUNT-1:0] tap_ff;
   logic [7:0] rx_byte;
   logic addr_match;
   logic nv_commit;

   assign rx_byte = rx_sh_ff;
   assign addr_match = (rx_byte[7:ADR_TYPE_POS] == DEVICE_TYPE_CODE) && !rx_byte[ADR_ZERO_POS] &&
                       (rx_byte[ADR_STRAP_POS +: 2] == line.strap) && !busy_ff;
   assign nv_commit = line.stop && nv_pend_ff && !busy_ff;

   // Serial engine; bus events act only on synchronised edges
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= DP_IDLE;
         bit_cnt_ff <= 4'h0;
         ack_phase_ff <= 1'b0;
         rx_sh_ff <= 8'h00;
         tx_sh_ff <= 8'h00;
         drive_low_ff <= 1'b0;
         rw_ff <= 1'b0;
         op_ff <= 3'h0;
         sel_ff <= 2'h0;
         byte_idx_ff <= 2'h0;
         data_lo_ff <= 8'h00;
         rd_val_ff <= WIPER_RST;
         wip_ld_ff <= 1'b0;
         wip_val_ff <= WIPER_RST;
         nv_pend_ff <= 1'b0;
         nv_sel_ff <= 2'h0;
         nv_val_ff <= PRESET_RST;
      end else begin
         wip_ld_ff <= 1'b0;
         if (line.start) begin
            state_ff <= DP_ADDR;
            bit_cnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            drive_low_ff <= 1'b0;
         end else if (line.stop) begin
            state_ff <= DP_IDLE;
            drive_low_ff <= 1'b0;
            nv_pend_ff <= 1'b0;
         end else if (state_ff == DP_IDLE) begin
            drive_low_ff <= 1'b0;
         end else if (state_ff == DP_IGNORE) begin
            // A final acknowledge stands until the falling edge that ends its clock
            if (line.scl_fall) begin
               drive_low_ff <= 1'b0;
            end
         end else if (line.scl_rise) begin
            if (!ack_phase_ff && bit_cnt_ff < BITS_PER_BYTE) begin
               rx_sh_ff <= {rx_sh_ff[6:0], line.sda};
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (ack_phase_ff && state_ff == DP_RDATA && line.sda) begin
               state_ff <= DP_IGNORE;
            end
         end else if (line.scl_fall) begin
            if (ack_phase_ff) begin
               ack_phase_ff <= 1'b0;
               bit_cnt_ff <= 4'h0;
               drive_low_ff <= 1'b0;
               if (state_ff == DP_RDATA) begin
                  if (byte_idx_ff == DATA_BYTES) begin
                     state_ff <= DP_IGNORE;
                  end else begin
                     tx_sh_ff <= (byte_idx_ff == 2'h0) ? rd_val_ff[7:0] : {6'h00, rd_val_ff[9:8]};
                     drive_low_ff <= (byte_idx_ff == 2'h0) ? ~rd_val_ff[7] : 1'b1;
                     byte_idx_ff <= byte_idx_ff + 2'h1;
                  end
               end
            end else if (state_ff == DP_RDATA) begin
               if (bit_cnt_ff == BITS_PER_BYTE) begin
                  drive_low_ff <= 1'b0;
                  ack_phase_ff <= 1'b1;
               end else begin
                  tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                  drive_low_ff <= ~tx_sh_ff[6];
               end
            end else if (bit_cnt_ff == BITS_PER_BYTE) begin
               ack_phase_ff <= 1'b1;
               unique case (state_ff)
                  DP_ADDR: begin
                     if (addr_match) begin
                        drive_low_ff <= 1'b1;
                        rw_ff <= rx_byte[ADR_RW_POS];
                        state_ff <= DP_CMD;
                     end else begin
                        state_ff <= DP_IGNORE;
                     end
                  end
                  DP_CMD: begin
                     op_ff <= rx_byte[7:CMD_OP_POS];
                     sel_ff <= rx_byte[CMD_SEL_POS +: 2];
                     byte_idx_ff <= 2'h0;
                     drive_low_ff <= 1'b1;
                     unique case (rx_byte[7:CMD_OP_POS])
                        OP_RD_WIPER, OP_RD_PRESET: begin
                           rd_val_ff <= (rx_byte[7:CMD_OP_POS] == OP_RD_WIPER) ? wiper_position_reg :
                                        preset_ff[rx_byte[CMD_SEL_POS +: 2]];
                           state_ff <= rw_ff ? DP_RDATA : DP_IGNORE;
                        end
                        OP_WR_WIPER, OP_WR_PRESET: begin
                           state_ff <= DP_WDATA;
                        end
                        OP_PRESET_TO_WIPER: begin
                           wip_ld_ff <= 1'b1;
                           wip_val_ff <= preset_ff[rx_byte[CMD_SEL_POS +: 2]];
                           state_ff <= DP_IGNORE;
                        end
                        OP_WIPER_TO_PRESET: begin
                           nv_pend_ff <= line.write_lock_n;
                           nv_sel_ff <= rx_byte[CMD_SEL_POS +: 2];
                           nv_val_ff <= wiper_position_reg;
                           state_ff <= DP_IGNORE;
                        end
                        default: begin
                           drive_low_ff <= 1'b0;
                           state_ff <= DP_IGNORE;
                        end
                     endcase
                  end
                  DP_WDATA: begin
                     drive_low_ff <= 1'b1;
                     if (byte_idx_ff == 2'h0) begin
                        data_lo_ff <= rx_byte;
                        byte_idx_ff <= 2'h1;
                     end else begin
                        state_ff <= DP_IGNORE;
                        if (op_ff == OP_WR_WIPER) begin
                           wip_ld_ff <= 1'b1;
                           wip_val_ff <= {rx_byte[1:0], data_lo_ff};
                        end else begin
                           nv_pend_ff <= line.write_lock_n;
                           nv_sel_ff <= sel_ff;
                           nv_val_ff <= {rx_byte[1:0], data_lo_ff};
                        end
                     end
                  end
                  default: begin
                     state_ff <= DP_IGNORE;
                  end
               endcase
            end
         end
      end
   end

   // Open drain: output level is always low, only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_low_ff;

   // Volatile wiper; recall happens one edge after reset release
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         recall_ff <= 1'b1;
         wiper_position_reg <= WIPER_RST;
      end else if (recall_ff) begin
         recall_ff <= 1'b0;
         wiper_position_reg <= preset_ff[0];
      end else if (wip_ld_ff) begin
         wiper_position_reg <= wip_val_ff;
      end
   end

   // Presets live in flip-flops, so every reset returns them to PRESET_RST
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < PRESET_NUM; i++) begin
            preset_ff[i] <= PRESET_RST;
         end
      end else if (nv_commit) begin
         preset_ff[nv_sel_ff] <= nv_val_ff;
      end
   end

   // Non-volatile write time blocks address acknowledge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_ff <= 1'b0;
         busy_cnt_ff <= 32'h0;
      end else if (nv_commit) begin
         busy_ff <= 1'b1;
         busy_cnt_ff <= 32'h0;
      end else if (busy_ff) begin
         busy_cnt_ff <= busy_cnt_ff + 32'h1;
         if (busy_cnt_ff == 32'(NV_CYCLES - 1)) begin
            busy_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tap_ff <= tap_decode(WIPER_RST);
      end else begin
         tap_ff <= tap_decode(wiper_position_reg);
      end
   end

   assign tap_sel_o = tap_ff;
   assign wiper_position_o = wiper_position_reg;
   assign nv_busy_o = busy_ff;
endmodule // dp_pot

/* File: test/dp_master_model.sv */
// Purpose: Behavioural 2-wire bus master driving the serial clock
// Assumes: 160 ns bus period, data line pulled up in the bench
// Notes: Low phase 100 ns so slave answers settle before the rise
`timescale 1ns/10ps
module dp_master_model (
   output logic scl_o,
   output logic sda_oe_o,
   input wire logic sda_i
);
   // Clock rests high between frames
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic start();
      #13;
      sda_oe_o = 1'b1;
      #50;
      scl_o = 1'b0;
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = ~b;
      #50;
      scl_o = 1'b1;
      #30;
      r = sda_i;
      #30;
      scl_o = 1'b0;
      #50;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask
   task automatic stop();
      sda_oe_o = 1'b1;
      #50;
      scl_o = 1'b1;
      #50;
      sda_oe_o = 1'b0;
      #100;
   endtask
endmodule // dp_master_model

/* File: test/dp_pot_chk.sv */
// Purpose: Port-level checks of the potentiometer slave
// Assumes: One clock domain, async active-low reset
// Notes: Busy time is counted in helper logic, not unrolled
`timescale 1ns/10ps
module dp_pot_chk
   import dp_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [WIPER_W-1:0] wiper_position_o,
   input wire logic [TAP_COUNT-1:0] tap_sel_o,
   input wire logic nv_busy_o
);
   int busy_cnt_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= nv_busy_o ? busy_cnt_ff + 1 : 0;
      end
   end
   a_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
   a_tap_follows: assert property (tap_sel_o == (TAP_COUNT'(1) << $past(wiper_position_o)))
      else $error("tap not from wiper");
   a_tap_onehot: assert property ($onehot(tap_sel_o)) else $error("tap not one-hot");
   // Answer lands three clocks after the fall, well inside the low phase
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("sda moved while scl high");
   a_busy_quiet: assert property (nv_busy_o |-> !sda_oe_o) else $error("drives while busy");
   a_busy_length: assert property ($fell(nv_busy_o) |-> busy_cnt_ff == NV_CYCLES)
      else $error("busy length wrong");
   a_busy_at_stop: assert property ($rose(nv_busy_o) |-> scl_i && sda_i) else $error("busy not at stop");
   a_wiper_idle: assert property ($changed(wiper_position_o) |-> !nv_busy_o) else $error("wiper moved busy");
   c_busy: cover property ($rose(nv_busy_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_wiper: cover property ($changed(wiper_position_o));
endmodule // dp_pot_chk
bind dp_pot dp_pot_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wiper_position_o(wiper_position_o),
   .tap_sel_o(tap_sel_o), .nv_busy_o(nv_busy_o));

/* File: test/tb_dp_pot.sv */
// Purpose: Self-checking bench for the potentiometer slave
// Assumes: Non-volatile write time shortened through NV_CYCLES
// Notes: Bus master runs on its own delays, unrelated to clk_i
`timescale 1ns/10ps
module tb_dp_pot
   import dp_pkg::*;
();
   localparam int NV_SIM = 200;
   logic clk_i;
   logic nrst_i = 1'b0;
   logic m_scl;
   logic m_oe;
   logic sda_oe;
   logic wl_n = 1'b1;
   logic busy;
   logic [1:0] strap = 2'b10;
   logic [WIPER_W-1:0] wiper;
   logic [TAP_COUNT-1:0] tap;
   wire logic sda_w;
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   // Pull-up: low whenever either party enables its driver
   assign sda_w = ~(m_oe | sda_oe);
   dp_master_model m (.scl_o(m_scl), .sda_oe_o(m_oe), .sda_i(sda_w));
   dp_pot #(.NV_CYCLES(NV_SIM)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(m_scl), .sda_i(sda_w), .sda_o(),
      .sda_oe_o(sda_oe), .addr_strap_high_i(strap[1]), .addr_strap_low_i(strap[0]), .write_lock_n_i(wl_n),
      .wiper_position_o(wiper), .tap_sel_o(tap), .nv_busy_o(busy));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         $display("BAD %0t timeout", $time);
         report_and_stop();
      end
   end
   task automatic chk_bit(input logic g, input logic e, input string s);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t %s", $time, s);
      end
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string s);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, s, g, e);
      end
   endtask
   // One whole frame; ea is the expected address acknowledge level
   task automatic op(input logic [1:0] st, input logic ea, input logic [2:0] opc, input logic [1:0] sel,
      input logic [9:0] v);
      logic [7:0] q0;
      logic [7:0] q1;
      logic a;
      logic rd;
      rd = (opc == OP_RD_WIPER) || (opc == OP_RD_PRESET);
      m.start();
      m.xfer({DEVICE_TYPE_CODE, 1'b0, st, rd}, 1'b1, q0, a);
      chk_bit(a, ea, "address ack");
      if (a === 1'b0) begin
         m.xfer({opc, 1'b0, sel, 2'b00}, 1'b1, q0, a);
         chk_bit(a, 1'b0, "command ack");
         if (rd) begin
            m.xfer(8'hff, 1'b0, q0, a);
            m.xfer(8'hff, 1'b1, q1, a);
            chk_word({q1, q0}, {6'h00, v}, "read data");
         end else if (opc[2]) begin
            m.xfer(v[7:0], 1'b1, q0, a);
            chk_bit(a, 1'b0, "data ack");
            m.xfer({6'h00, v[9:8]}, 1'b1, q0, a);
            chk_bit(a, 1'b0, "data ack");
         end
      end
      m.stop();
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk_bit(busy, 1'b0, "busy ends");
   endtask
   task automatic do_reset();
      nrst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk_word({6'h00, wiper}, {6'h00, PRESET_RST}, "recall");
      chk_bit(tap[PRESET_RST], 1'b1, "tap after reset");
   endtask
   task automatic chk_wiper(input logic [9:0] v);
      chk_word({6'h00, wiper}, {6'h00, v}, "wiper");
      chk_bit(tap[v], 1'b1, "tap");
   endtask
   initial begin
      do_reset();
      $display("test reset done");
      op(2'b10, 1'b0, OP_WR_WIPER, 2'b00, 10'h155);
      chk_wiper(10'h155);
      op(2'b10, 1'b0, OP_RD_WIPER, 2'b00, 10'h155);
      op(2'b01, 1'b1, OP_WR_WIPER, 2'b00, 10'h0aa);
      chk_wiper(10'h155);
      $display("test wiper done");
      op(2'b10, 1'b0, OP_WR_PRESET, 2'b10, 10'h2aa);
      chk_bit(busy, 1'b1, "busy after stop");
      op(2'b10, 1'b1, OP_RD_WIPER, 2'b00, 10'h000);
      wait_idle();
      op(2'b10, 1'b0, OP_RD_PRESET, 2'b10, 10'h2aa);
      op(2'b10, 1'b0, OP_PRESET_TO_WIPER, 2'b10, 10'h000);
      chk_wiper(10'h2aa);
      op(2'b10, 1'b0, OP_WIPER_TO_PRESET, 2'b11, 10'h000);
      wait_idle();
      op(2'b10, 1'b0, OP_RD_PRESET, 2'b11, 10'h2aa);
      $display("test presets done");
      @(posedge clk_i);
      wl_n <= 1'b0;
      op(2'b10, 1'b0, OP_WR_PRESET, 2'b01, 10'h3ff);
      chk_bit(busy, 1'b0, "locked write busy");
      op(2'b10, 1'b0, OP_WR_WIPER, 2'b00, 10'h3ff);
      chk_wiper(10'h3ff);
      op(2'b10, 1'b0, OP_RD_PRESET, 2'b01, PRESET_RST);
      $display("test lock done");
      @(posedge clk_i);
      do_reset();
      $display("test second reset done");
      report_and_stop();
   end
endmodule // tb_dp_pot
